// [bench/dsc_chk_sva.sv]
`timescale 1ns/100ps
// ---------
// port checks for one source channel
// ---------
module dsc_chk import dsc_pkg::*; #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic [N_IN-1:0] IN_N,
   input wire logic [N_OUT-1:0] RELAY,
   input wire logic [2:0] DAC_SEL,
   input wire logic [2:0] RANGE_CODE,
   input wire logic RUNNING
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   wire w_rg = WR && CE && ADDR == A_RANGE;
   wire w_dac = WR && CE && ADDR == A_DAC;
   wire w_cmd = WR && CE && ADDR == A_CMD;
   wire s_go = w_cmd && WDATA[CMD_START] && !WDATA[CMD_STOP];
   a_range_load: assert property (w_rg && WDATA <= 32'h5 |=> ##1
      RANGE_CODE == $past(WDATA[2:0], 2)) else $error("range not loaded");
   a_range_keep: assert property (w_rg && WDATA > 32'h5 |=> ##1
      $stable(RANGE_CODE)) else $error("bad range taken");
   a_dac_load: assert property (w_dac && WDATA <= 32'h6 |=> ##1
      DAC_SEL == $past(WDATA[2:0], 2)) else $error("output not loaded");
   a_dac_keep: assert property (w_dac && WDATA > 32'h6 |=> ##1
      $stable(DAC_SEL)) else $error("bad output taken");
   a_range_span: assert property (RANGE_CODE <= RANGE_MAX)
      else $error("range code out of span");
   a_reset_vals: assert property (disable iff (1'b0) !RST_N |=>
      RANGE_CODE == RANGE_RST && DAC_SEL == 3'h0 && RELAY == '0 && !RUNNING)
      else $error("reset values wrong");
   a_nodac_stop: assert property (s_go && DAC_SEL == 3'h0
      && !RUNNING && !$past(w_dac) |=> !RUNNING [*3])
      else $error("ran without output");
   a_go_runs: assert property (s_go && DAC_SEL != 3'h0
      && !RUNNING && !$past(w_dac) |-> ##2 RUNNING)
      else $error("start not taken");
   a_stop_halts: assert property (w_cmd && WDATA[CMD_STOP] && RUNNING
      |-> ##2 !RUNNING) else $error("stop not taken");
   a_state_shape: assert property (RD && CE && ADDR == A_STATUS |=>
      $onehot(RDATA[5:0]) && RDATA[31:9] == 23'h0) else $error("bad status");
   c_start: cover property (s_go ##2 RUNNING);
   c_bad_range: cover property (w_rg && WDATA > 32'h0000_0005);
   c_stop: cover property (w_cmd && WDATA[CMD_STOP] && RUNNING);
endmodule
bind dsc_channel dsc_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
   .WR(WR), .RD(RD), .RDATA(RDATA), .IN_N(IN_N), .RELAY(RELAY),
   .DAC_SEL(DAC_SEL), .RANGE_CODE(RANGE_CODE), .RUNNING(RUNNING));

// [bench/dsc_indexer.sv]
`timescale 1ns/100ps
// ---------
// turret indexer, closes feedback contact lag cycles after go
// ---------
module dsc_indexer import dsc_pkg::*; (
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] lag,
   input wire logic [4:0] line,
   output logic [N_IN-1:0] in_n
);
   logic [7:0] cnt;
   always_ff @(posedge clk) begin
      if (!go) begin
         cnt <= 8'h00;
      end else if (cnt != lag) begin
         cnt <= cnt + 8'h01;
      end
   end
   // open contacts sit at the pull-up level
   always_comb begin
      in_n = '1;
      if (go && cnt == lag && line != 5'h00) begin
         in_n[line - 5'h01] = 1'b0;
      end
   end
endmodule

// [bench/tb.sv]
`timescale 1ns/100ps
module tb import dsc_pkg::*; ;
   logic SYS_CLK = 1'b0, RST_N = 1'b0, CE = 1'b1, WR = 1'b0, RD = 1'b0;
   logic [3:0] ADDR = 4'h0;
   logic [31:0] WDATA = 32'h0000_0000;
   logic [31:0] RDATA, d;
   logic [N_IN-1:0] IN_N;
   logic [N_OUT-1:0] RELAY;
   logic [2:0] DAC_SEL, RANGE_CODE;
   logic RUNNING;
   logic go = 1'b0;
   logic [4:0] fb_line = 5'h00;
   int miscompares = 0, check_count = 0, cyc = 0, n;
   logic [3:0] ra [13] = '{A_DAC, A_RANGE, A_SHUT, A_SHUT_POL, A_NCRUC,
      A_CRUC_OUT, A_CRUC_POL, A_FB_EN, A_TUR_IN, A_TUR_DLY, A_SNS_TYPE,
      A_STATUS, 4'hE};
   logic [7:0] rv [13] = '{8'h00, 8'h03, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h05, 8'h09, 8'h01, 8'h00};
   logic [3:0] ba [11] = '{A_RANGE, A_DAC, A_SHUT, A_NCRUC, A_NCRUC,
      A_CRUC_OUT, A_TUR_IN, A_TUR_DLY, A_TUR_DLY, A_SNS_TYPE, A_SNS_TYPE};
   logic [7:0] bv [11] = '{8'h06, 8'h07, 8'h27, 8'h05, 8'h02, 8'h26, 8'h1D,
      8'h00, 8'h3D, 8'h06, 8'h00};
   logic [7:0] bk [11] = '{8'h05, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00,
      8'h05, 8'h05, 8'h11, 8'h11};
   logic [7:0] nc [6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h01};
   logic [7:0] sv [4] = '{8'h0C, 8'h0E, 8'h04, 8'h02};
   logic [7:0] se [4] = '{8'h0E, 8'h0F, 8'h12, 8'h11};
   dsc_channel #(.TICK_CYCLES(10)) dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
      .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .IN_N(IN_N), .RELAY(RELAY), .DAC_SEL(DAC_SEL),
      .RANGE_CODE(RANGE_CODE), .RUNNING(RUNNING));
   dsc_indexer u_idx (.clk(SYS_CLK), .go(go), .lag(8'h06), .line(fb_line),
      .in_n(IN_N));
   initial begin
      forever #12.5 SYS_CLK = ~SYS_CLK;
   end
   // ---------
   // bus tasks, one idle edge between strobes
   // ---------
   task automatic chk(input string nm, input logic [63:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge SYS_CLK);
      ADDR <= a;
      WDATA <= {24'h00_0000, v};
      WR <= 1'b1;
      @(posedge SYS_CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge SYS_CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge SYS_CLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask
   task automatic rchk(input string nm, input logic [3:0] a,
         input logic [31:0] e);
      rd(a);
      chk(nm, d, e);
   endtask
   task automatic tk(input int k);
      repeat (k) @(posedge SYS_CLK);
      #1;
   endtask
   task automatic wait_st(input logic [5:0] st, input int lim);
      n = 0;
      do begin
         rd(A_STATUS);
         n++;
      end while (d[5:0] !== st && n < lim);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   // ---------
   // main sequence
   // ---------
   initial begin
      tk(8);
      chk("reset_out", {RELAY, DAC_SEL, RANGE_CODE, RUNNING}, 45'h6);
      @(posedge SYS_CLK);
      RST_N <= 1'b1;
      for (int i = 0; i < 13; i++) rchk("reset_reg", ra[i], rv[i]);
      $display("reset test done");
      for (int i = 0; i < 6; i++) begin
         wr(A_RANGE, 8'(i));
         tk(1);
         chk("range", RANGE_CODE, i);
      end
      // a write while the enable is low must leave no trace
      @(posedge SYS_CLK);
      CE <= 1'b0;
      wr(A_RANGE, 8'h02);
      CE <= 1'b1;
      rchk("ce_hold", A_RANGE, 8'h05);
      for (int i = 0; i < 6; i++) begin
         wr(A_NCRUC, nc[i]);
         rchk("ncruc", A_NCRUC, nc[i]);
      end
      for (int i = 0; i < 4; i++) begin
         wr(A_SNS_TYPE, sv[i]);
         rchk("sensor", A_SNS_TYPE, se[i]);
      end
      for (int i = 0; i < 11; i++) begin
         wr(ba[i], bv[i]);
         rchk("kept", ba[i], bk[i]);
         rchk("cfg_err", A_STATUS, 32'h0000_0101);
         wr(A_CMD, 8'h20);
      end
      $display("config test done");
      wr(A_DAC, 8'h00);
      wr(A_CMD, 8'h01);
      rchk("no_dac", A_STATUS, 8'hA0);
      wr(A_CMD, 8'h20);
      wr(A_DAC, 8'h02);
      tk(1);
      chk("dac_sel", DAC_SEL, 8'h02);
      wr(A_NCRUC, 8'h40);
      wr(A_CRUC_OUT, 8'h03);
      wr(A_POS, 8'h2A);
      tk(1);
      chk("cruc64", RELAY, 38'h00_0000_00A8);
      wr(A_CRUC_POL, 8'h01);
      tk(1);
      chk("cruc_pol", RELAY, 38'h00_0000_0054);
      wr(A_CRUC_POL, 8'h00);
      wr(A_NCRUC, 8'h04);
      wr(A_POS, 8'h03);
      tk(1);
      chk("cruc4", RELAY, 38'h00_0000_000C);
      wr(A_TUR_DLY, 8'h02);
      wr(A_CMD, 8'h01);
      wait_st(6'h04, 20);
      chk("dly_win", n >= 10 && n <= 12, 1'b1);
      chk("rise", d, 8'h04);
      wr(A_SNS_TYPE, 8'h0C);
      rchk("sns_run", A_SNS_TYPE, 8'h11);
      wr(A_CMD, 8'h20);
      $display("crucible test done");
      wr(A_SHUT, 8'h0A);
      // manual is only reachable from deposit
      wr(A_CMD, 8'h04);
      wr(A_CMD, 8'h08);
      tk(1);
      chk("shut_man", RELAY[9], 1'b1);
      wr(A_CMD, 8'h02);
      tk(1);
      chk("shut_stop", RELAY[9], 1'b0);
      wr(A_CMD, 8'h01);
      wait_st(6'h04, 20);
      wr(A_CMD, 8'h04);
      tk(1);
      chk("shut_dep", RELAY[9], 1'b1);
      wr(A_CMD, 8'h10);
      tk(1);
      chk("shut_end", RELAY[9], 1'b0);
      wr(A_SHUT_POL, 8'h01);
      tk(1);
      chk("shut_pol", RELAY[9], 1'b1);
      wr(A_CMD, 8'h02);
      wr(A_NCRUC, 8'h01);
      tk(1);
      chk("one_pocket", RELAY[3:2], 2'h0);
      wr(A_CMD, 8'h01);
      rchk("no_switch", A_STATUS, 8'h04);
      wr(A_CMD, 8'h02);
      $display("shutter test done");
      wr(A_NCRUC, 8'h04);
      wr(A_FB_EN, 8'h01);
      wr(A_TUR_IN, 8'h04);
      fb_line <= 5'h04;
      wr(A_CMD, 8'h01);
      tk(30);
      rchk("fb_wait", A_STATUS, 8'h02);
      go <= 1'b1;
      wait_st(6'h04, 12);
      chk("fb_seen", d, 8'h04);
      wr(A_CMD, 8'h02);
      go <= 1'b0;
      wr(A_TUR_IN, 8'h00);
      wr(A_CMD, 8'h01);
      tk(500);
      rchk("no_input", A_STATUS, 8'h02);
      wait_st(6'h20, 80);
      chk("fb_timeout", d, 8'h60);
      $display("feedback test done");
      end_of_test();
   end
endmodule

// [rtl/dsc_channel.sv]
`timescale 1ns/100ps
module dsc_channel import dsc_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYC
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic [3:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic [N_IN-1:0] IN_N,
   output logic [N_OUT-1:0] RELAY,
   output logic [2:0] DAC_SEL,
   output logic [2:0] RANGE_CODE,
   output logic RUNNING
);
   // ----------------------------------------
   // configuration and bus
   // ----------------------------------------
   dsc_bus_s bus;
   dsc_err_s err;
   dsc_state_e state, next_state;
   logic [2:0] dac_sel, range_code;
   logic [5:0] shut_sel, cruc_sel, tur_dly;
   logic [4:0] tur_in;
   logic [6:0] ncruc;
   logic shut_pol, cruc_pol, fb_en;
   logic [2:0] sns_type [N_SNS];
   logic [5:0] pos;
   logic [N_IN-1:0] in_s1, in_s2;
   logic tick, fb_hit, start, stop, wr_ok, running;
   logic [5:0] sec;

   assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   assign running = (state != ST_IDLE) && (state != ST_STOP);

   function automatic logic ncruc_ok(input logic [31:0] v);
      return v == 32'h1 || v == 32'h4 || v == 32'h8 || v == 32'h10
         || v == 32'h20 || v == 32'h40;
   endfunction

   function automatic logic [2:0] code_bits(input logic [6:0] n);
      case (n)
         7'h04: code_bits = 3'h2;
         7'h08: code_bits = 3'h3;
         7'h10: code_bits = 3'h4;
         7'h20: code_bits = 3'h5;
         7'h40: code_bits = 3'h6;
         default: code_bits = 3'h0;
      endcase
   endfunction

   function automatic logic sns_ok(input logic [31:0] v);
      return v == 32'h1 || v == 32'h2 || v == 32'h6 || v == 32'h7;
   endfunction

   // validity of each write, refused values keep the old setting
   always_comb begin
      wr_ok = 1'b1;
      if (bus.addr == A_DAC) begin
         wr_ok = bus.wdata <= 32'(DAC_MAX);
      end else if (bus.addr == A_RANGE) begin
         wr_ok = bus.wdata <= 32'(RANGE_MAX);
      end else if (bus.addr == A_SHUT) begin
         wr_ok = bus.wdata <= 32'(SHUT_MAX);
      end else if (bus.addr == A_SHUT_POL || bus.addr == A_CRUC_POL
            || bus.addr == A_FB_EN) begin
         wr_ok = bus.wdata <= 32'h1;
      end else if (bus.addr == A_NCRUC) begin
         wr_ok = ncruc_ok(bus.wdata);
      end else if (bus.addr == A_CRUC_OUT) begin
         wr_ok = bus.wdata <= 32'(CRUC_MAX);
      end else if (bus.addr == A_TUR_IN) begin
         wr_ok = bus.wdata <= 32'(TIN_MAX);
      end else if (bus.addr == A_TUR_DLY) begin
         wr_ok = bus.wdata >= 32'(DLY_MIN)
            && bus.wdata <= 32'(DLY_MAX);
      end else if (bus.addr == A_SNS_TYPE) begin
         wr_ok = sns_ok({1'b0, bus.wdata[31:1]}) && !running;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         dac_sel <= 3'h0;
         range_code <= RANGE_RST;
         shut_sel <= 6'h00;
         shut_pol <= 1'b0;
         ncruc <= NCRUC_RST;
         cruc_sel <= 6'h00;
         cruc_pol <= 1'b0;
         fb_en <= 1'b0;
         tur_in <= 5'h00;
         tur_dly <= DLY_RST;
         pos <= 6'h00;
      end else if (CE && bus.wr && wr_ok) begin
         if (bus.addr == A_DAC) begin
            dac_sel <= bus.wdata[2:0];
         end else if (bus.addr == A_RANGE) begin
            range_code <= bus.wdata[2:0];
         end else if (bus.addr == A_SHUT) begin
            shut_sel <= bus.wdata[5:0];
         end else if (bus.addr == A_SHUT_POL) begin
            shut_pol <= bus.wdata[0];
         end else if (bus.addr == A_NCRUC) begin
            ncruc <= bus.wdata[6:0];
         end else if (bus.addr == A_CRUC_OUT) begin
            cruc_sel <= bus.wdata[5:0];
         end else if (bus.addr == A_CRUC_POL) begin
            cruc_pol <= bus.wdata[0];
         end else if (bus.addr == A_FB_EN) begin
            fb_en <= bus.wdata[0];
         end else if (bus.addr == A_TUR_IN) begin
            tur_in <= bus.wdata[4:0];
         end else if (bus.addr == A_TUR_DLY) begin
            tur_dly <= bus.wdata[5:0];
         end else if (bus.addr == A_POS) begin
            pos <= bus.wdata[5:0];
         end
      end
   end

   // sensor pair: bit 0 picks the sensor of the pair, value above it
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         for (int i = 0; i < N_SNS; i++) begin
            sns_type[i] <= SNS_RST;
         end
      end else if (CE && bus.wr && wr_ok && bus.addr == A_SNS_TYPE) begin
         sns_type[bus.wdata[0]] <= bus.wdata[3:1];
         if (!bus.wdata[0] && bus.wdata[3:1] == SNS_DUAL) begin
            sns_type[1] <= SNS_DUAL;
         end
      end
   end

   // ----------------------------------------
   // feedback input sync
   // ----------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         in_s1 <= '1;
         in_s2 <= '1;
      end else if (CE) begin
         in_s1 <= IN_N;
         in_s2 <= in_s1;
      end
   end

   // low level is asserted; no input assigned never hits
   assign fb_hit = (tur_in != 5'h00)
      && !in_s2[5'(tur_in - 5'h01)];

   // ----------------------------------------
   // sequencer
   // ----------------------------------------
   assign start = bus.wr && bus.addr == A_CMD && bus.wdata[CMD_START];
   assign stop = bus.wr && bus.addr == A_CMD && bus.wdata[CMD_STOP];

   dsc_tick #(.CYC(TICK_CYCLES)) u_tick (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .ce(CE),
      .run(state == ST_SWITCH),
      .tick(tick)
   );

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N || state != ST_SWITCH) begin
         sec <= 6'h00;
      end else if (CE && tick) begin
         sec <= sec + 6'h01;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE, ST_STOP: begin
            if (start && dac_sel == 3'h0) begin
               next_state = ST_STOP;
            end else if (start && ncruc == NCRUC_RST) begin
               next_state = ST_RISE1;
            end else if (start) begin
               next_state = ST_SWITCH;
            end
         end
         ST_SWITCH: begin
            if (fb_en && fb_hit) begin
               next_state = ST_RISE1;
            end else if (fb_en && tick
                  && sec == 6'(FB_TIMEOUT_S - 1)) begin
               next_state = ST_STOP;
            end else if (!fb_en && tick && sec == tur_dly - 6'h01) begin
               next_state = ST_RISE1;
            end
         end
         ST_RISE1: begin
            if (bus.wr && bus.addr == A_CMD && bus.wdata[CMD_DEP]) begin
               next_state = ST_DEPOSIT;
            end
         end
         ST_DEPOSIT, ST_MANUAL: begin
            if (bus.wr && bus.addr == A_CMD && bus.wdata[CMD_DEP_END]) begin
               next_state = ST_IDLE;
            end else if (bus.wr && bus.addr == A_CMD
                  && bus.wdata[CMD_MAN]) begin
               next_state = ST_MANUAL;
            end else if (bus.wr && bus.addr == A_CMD
                  && bus.wdata[CMD_DEP]) begin
               next_state = ST_DEPOSIT;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      if (stop && state != ST_IDLE) begin
         next_state = ST_STOP;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         state <= ST_IDLE;
      end else if (CE) begin
         state <= next_state;
      end
   end

   // ----------------------------------------
   // sticky errors, set wins over clear
   // ----------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         err <= '0;
      end else if (CE) begin
         if (bus.wr && bus.addr == A_CMD && bus.wdata[CMD_CLR_ERR]) begin
            err <= '0;
         end
         if (bus.wr && !wr_ok) begin
            err.cfg_err <= 1'b1;
         end
         if (start && state inside {ST_IDLE, ST_STOP} && dac_sel == 3'h0) begin
            err.no_dac_err <= 1'b1;
         end
         if (state == ST_SWITCH && next_state == ST_STOP && !stop) begin
            err.fb_timeout <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // relay drive
   // ----------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         RELAY <= '0;
      end else if (CE) begin
         for (int i = 0; i < N_OUT; i++) begin
            RELAY[i] <= 1'b0;
            // lsb on the first selected line
            if (ncruc != NCRUC_RST && cruc_sel != 6'h00
                  && i >= int'(cruc_sel) - 1
                  && i < int'(cruc_sel) - 1 + int'(code_bits(ncruc))) begin
               RELAY[i] <= pos[i - int'(cruc_sel) + 1]
                  ^ cruc_pol;
            end
            if (shut_sel != 6'h00 && i == int'(shut_sel) - 1) begin
               RELAY[i] <= (state inside {ST_DEPOSIT, ST_MANUAL})
                  ^ shut_pol;
            end
         end
      end
   end

   // ----------------------------------------
   // read port, one cycle latency
   // ----------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         RDATA <= 32'h0000_0000;
      end else if (CE) begin
         RDATA <= 32'h0000_0000;
         if (bus.rd) begin
            if (bus.addr == A_DAC) begin
               RDATA <= {29'h0, dac_sel};
            end else if (bus.addr == A_RANGE) begin
               RDATA <= {29'h0, range_code};
            end else if (bus.addr == A_SHUT) begin
               RDATA <= {26'h0, shut_sel};
            end else if (bus.addr == A_SHUT_POL) begin
               RDATA <= {31'h0, shut_pol};
            end else if (bus.addr == A_NCRUC) begin
               RDATA <= {25'h0, ncruc};
            end else if (bus.addr == A_CRUC_OUT) begin
               RDATA <= {26'h0, cruc_sel};
            end else if (bus.addr == A_CRUC_POL) begin
               RDATA <= {31'h0, cruc_pol};
            end else if (bus.addr == A_FB_EN) begin
               RDATA <= {31'h0, fb_en};
            end else if (bus.addr == A_TUR_IN) begin
               RDATA <= {27'h0, tur_in};
            end else if (bus.addr == A_TUR_DLY) begin
               RDATA <= {26'h0, tur_dly};
            end else if (bus.addr == A_SNS_TYPE) begin
               RDATA <= {26'h0, sns_type[1], sns_type[0]};
            end else if (bus.addr == A_STATUS) begin
               RDATA <= {23'h0, err, state};
            end else if (bus.addr == A_POS) begin
               RDATA <= {26'h0, pos};
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         DAC_SEL <= 3'h0;
         RANGE_CODE <= RANGE_RST;
         RUNNING <= 1'b0;
      end else if (CE) begin
         DAC_SEL <= dac_sel;
         RANGE_CODE <= range_code;
         RUNNING <= running;
      end
   end
endmodule

// [rtl/dsc_pkg.sv]
// Function
// - up to six source channels, two sensors standard, paired, extendable to eight
// - output selector 0..6; 1..6 pick analog output, 0 none
// - range code 0..5 picks span 10,5,2.5,-10,-5,-2.5 V; default 3
// - shutter selector 0..38; nonzero names output line; 0 disables
// - shutter condition true in deposit or manual; drops at end or stop
// - shutter polarity: 0 normally open, 1 normally closed, inverts drive
// - crucible count only 1,4,8,16,32,64; default 1 means no indexing
// - with one crucible, crucible outputs and turret settings are ignored
// - position register driven as plain binary on 2..6 lines
// - crucible start selector 0..37 names first line; 0 inactive
// - code lsb on first selected line, higher bits on following lines
// - crucible polarity sets idle state of all crucible lines
// - turret feedback flag picks feedback wait or delay timer; default off
// - with feedback, enter switch state on start; stop after 60 s
// - turret input selector 0..28; nonzero picks input line; 0 none
// - feedback on with no input assigned never leaves switch on feedback
// - without feedback wait programmed 1..60 s, default 5, then rise one
// - delay expiry advances to rise one without checking position
// - sensor type only 1,2,6,7; default 1
// - writing first sensor type 2 forces paired second sensor to 2
// - sensor type writes refused while a process runs
// - start with output selector 0 forces stop and missing-output error
package dsc_pkg;
   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [3:0] A_DAC = 4'h0;
   localparam logic [3:0] A_RANGE = 4'h1;
   localparam logic [3:0] A_SHUT = 4'h2;
   localparam logic [3:0] A_SHUT_POL = 4'h3;
   localparam logic [3:0] A_NCRUC = 4'h4;
   localparam logic [3:0] A_CRUC_OUT = 4'h5;
   localparam logic [3:0] A_CRUC_POL = 4'h6;
   localparam logic [3:0] A_FB_EN = 4'h7;
   localparam logic [3:0] A_TUR_IN = 4'h8;
   localparam logic [3:0] A_TUR_DLY = 4'h9;
   localparam logic [3:0] A_SNS_TYPE = 4'hA;
   localparam logic [3:0] A_CMD = 4'hB;
   localparam logic [3:0] A_STATUS = 4'hC;
   localparam logic [3:0] A_POS = 4'hD;
   // ----------------------------------------
   // reset values and limits
   // ----------------------------------------
   localparam logic [2:0] RANGE_RST = 3'h3;
   localparam logic [2:0] RANGE_MAX = 3'h5;
   localparam logic [2:0] DAC_MAX = 3'h6;
   localparam logic [5:0] SHUT_MAX = 6'h26;
   localparam logic [5:0] CRUC_MAX = 6'h25;
   localparam logic [4:0] TIN_MAX = 5'h1C;
   localparam logic [5:0] DLY_RST = 6'h05;
   localparam logic [5:0] DLY_MIN = 6'h01;
   localparam logic [5:0] DLY_MAX = 6'h3C;
   localparam logic [6:0] NCRUC_RST = 7'h01;
   localparam logic [2:0] SNS_RST = 3'h1;
   localparam logic [2:0] SNS_DUAL = 3'h2;
   localparam int N_OUT = 38;
   localparam int N_IN = 28;
   localparam int N_SNS = 2;
   // ----------------------------------------
   // command bits and timing
   // ----------------------------------------
   localparam int CMD_START = 0;
   localparam int CMD_STOP = 1;
   localparam int CMD_DEP = 2;
   localparam int CMD_MAN = 3;
   localparam int CMD_DEP_END = 4;
   localparam int CMD_CLR_ERR = 5;
   localparam int FB_TIMEOUT_S = 60;
   localparam int CLK_HZ = 40_000_000;
   localparam int TICK_CYC = CLK_HZ;
   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [5:0] {
      ST_IDLE = 6'b00_0001,
      ST_SWITCH = 6'b00_0010,
      ST_RISE1 = 6'b00_0100,
      ST_DEPOSIT = 6'b00_1000,
      ST_MANUAL = 6'b01_0000,
      ST_STOP = 6'b10_0000
   } dsc_state_e;
   typedef struct packed {
      logic [3:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } dsc_bus_s;
   typedef struct packed {
      logic cfg_err;
      logic no_dac_err;
      logic fb_timeout;
   } dsc_err_s;
endpackage

// [rtl/dsc_tick.sv]
`timescale 1ns/100ps
// ----------------------------------------
// one-second timebase
// ----------------------------------------
module dsc_tick import dsc_pkg::*; #(
   parameter int CYC = TICK_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic run,
   output logic tick
);
   logic [31:0] cnt;
   initial begin
      if (CYC < 1) $error("dsc_tick: CYC must be at least 1");
   end
   // restart on run low so each wait counts whole seconds
   always_ff @(posedge clk) begin
      if (!rst_n || !run) begin
         cnt <= 32'h0000_0000;
         tick <= 1'b0;
      end else if (ce) begin
         tick <= (cnt == 32'(CYC - 1));
         cnt <= (cnt == 32'(CYC - 1)) ? 32'h0000_0000 : cnt + 32'h0000_0001;
      end
   end
endmodule
